/* File: hdl/sss_serial_slave.sv */
// sss_serial_slave: two-wire slave for the sensor registers, the 256-byte eeprom and
// its lower-half write protection, with bus timeout and alert response.
// assumes: sensor register file and event logic on mclk outside; bus pins asynchronous.
//
// Behaviour
// - timeout enabled: scl low over 35 ms sends state machine idle, releases sda
// - timeout on after reset; bus option bit 7 set disables it
// - scl is only sampled, never driven or stretched
// - alert address acked only in interrupt mode with polarity bit zero
// - alert reply arbitrates bitwise; winner finishes then releases event output
// - alert support off after reset; bus option bit 0 cleared enables it
// - pointer resets to 00h and holds last written value
// - register writes: address, pointer, then exactly two data bytes
// - bytes go msb first; read end accepts ack or nack
// - a new temperature value is latched every 125 ms
// - eeprom written as single bytes, partial or full 16-byte pages
// - byte write acked three times; stop starts the internal write
// - address high nibble is page, low nibble wraps within page
// - while writing internally, every address is left unacknowledged
// - 1010b selects memory, 0110b protection; low bits match select pins
// - protection set/clear need overvoltage with given pins; permanent needs match
// - protection state is kept outside in nonvolatile cells
// - protection encodings write with r/w zero, read status with r/w one
// - ack needs full address match, byte bit 1 ignored for set/clear; no protection command after permanent
// - protected lower half: data byte nacked, no write cycle
// - current address read returns next byte, wraps whole memory
`timescale 1ns/100ps

module sss_serial_slave
    import sss_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `SSS_TIMEOUT_MS * `SSS_MCLK_KHZ,
    parameter int unsigned CONV_CYC = `SSS_CONV_MS * `SSS_MCLK_KHZ,
    parameter int unsigned WRITE_CYC = `SSS_WRITE_MS * `SSS_MCLK_KHZ
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    output logic sda_pin_out,
    output logic sda_pin_oe,
    input wire logic select_pin_low,
    input wire logic select_pin_mid,
    input wire logic select_pin_high,
    input wire logic overvoltage_detect,
    input wire logic ev_int_mode,
    input wire logic ev_pol_high,
    input wire logic ev_asserted,
    input wire logic [15:0] reg_rdata,
    input wire logic nv_rwp,
    input wire logic nv_pwp,
    output logic [7:0] reg_ptr,
    output logic [15:0] reg_wdata,
    output logic reg_we,
    output logic temp_latch,
    output logic event_clear,
    output logic prot_rwp,
    output logic prot_pwp,
    output logic write_busy
);

    localparam logic [`SSS_CNT_W-1:0] TO_LIM = `SSS_CNT_W'(TIMEOUT_CYC);
    localparam logic [`SSS_CNT_W-1:0] CONV_LIM = `SSS_CNT_W'(CONV_CYC - 1);
    localparam logic [`SSS_CNT_W-1:0] WR_LIM = `SSS_CNT_W'(WRITE_CYC - 1);

    sss_core_s s;
    sss_core_s n;
    sss_pins_s pins_in;
    logic [7:0] mem [0:`SSS_MEM_BYTES-1];
    logic [7:0] mem_q;
    logic [7:0] tx_next;
    logic [7:0] rx;
    logic load;
    logic rise;
    logic fall;

    // byte to put on the bus for the current read target
    function automatic logic [7:0] tx_byte(sss_tgt_e t, logic lo, logic [15:0] w,
                                           logic [7:0] m, logic [2:0] sel);
        case (t)
            TG_MEM: tx_byte = m;
            TG_TS: tx_byte = lo ? w[7:0] : w[15:8];
            TG_ARA: tx_byte = {`SSS_FIX_TS, sel, 1'b0};
            default: tx_byte = 8'hFF; // status reads leave sda released
        endcase
    endfunction

    assign pins_in = {scl_pin, sda_pin_in, overvoltage_detect,
                      select_pin_high, select_pin_mid, select_pin_low};
    assign mem_q = mem[s.mem_addr];
    assign tx_next = tx_byte(s.tgt, s.rd_lo, s.rdw, mem_q, s.ps.sel);
    assign rx = {s.sh[6:0], s.ps.sda};
    // edges from second stage only; first stage feeds nothing else
    assign rise = s.ps.scl & ~s.scl_d;
    assign fall = ~s.ps.scl & s.scl_d;

    // whole next-state logic
    always_comb begin
        n = s;
        load = 1'b0;
        n.reg_we = 1'b0;
        n.ev_clr = 1'b0;
        n.conv_tick = 1'b0;
        n.commit = 1'b0;
        n.pm = pins_in;
        n.ps = s.pm;
        n.scl_d = s.ps.scl;
        n.sda_d = s.ps.sda;

        // conversion period marker
        if (s.conv_cnt == CONV_LIM) begin
            n.conv_cnt = '0;
            n.conv_tick = 1'b1;
        end else begin
            n.conv_cnt = s.conv_cnt + 1'b1;
        end

        // scl low time, saturating at the limit
        if (s.ps.scl) begin
            n.to_cnt = '0;
        end else if (s.to_cnt != TO_LIM) begin
            n.to_cnt = s.to_cnt + 1'b1;
        end

        // internal write cycle; results land only when it ends
        if (s.busy) begin
            if (s.busy_cnt == WR_LIM) begin
                n.busy = 1'b0;
                if (s.prot_pend) begin
                    n.prot_pend = 1'b0;
                    case (s.pcmd)
                        PC_PERM: n.permanent_protect_cmd = 1'b1;
                        PC_REV: n.reversible_protect_cmd = 1'b1;
                        default: n.reversible_protect_cmd = 1'b0;
                    endcase
                end else begin
                    n.commit = 1'b1;
                    n.wr_pend = 1'b0;
                end
            end else begin
                n.busy_cnt = s.busy_cnt + 1'b1;
            end
        end

        case (s.st)
            ST_RX: begin
                if (rise) begin
                    n.sh = rx;
                    n.bitc = s.bitc + 1'b1;
                    if (s.bitc == 4'h7) begin
                        n.st = ST_ACKW;
                        n.ack = 1'b1;
                        n.byte_n = (s.byte_n == 3'h7) ? s.byte_n : s.byte_n + 1'b1;
                        if (s.byte_n == 3'h0) begin
                            // address decode
                            n.rw = rx[0];
                            n.ack = 1'b0;
                            n.rd_lo = 1'b0;
                            if (s.busy) begin
                                n.ack = 1'b0;
                            end else if (rx[7:1] == {`SSS_FIX_MEM, s.ps.sel} && !s.ps.ov) begin
                                n.tgt = TG_MEM;
                                n.ack = 1'b1;
                            end else if (rx[7:1] == {`SSS_FIX_TS, s.ps.sel} && !s.ps.ov) begin
                                n.tgt = TG_TS;
                                n.ack = 1'b1;
                                // frozen so a conversion mid-read cannot tear it
                                n.rdw = (s.ptr == `SSS_PTR_BUSOPT) ? {8'h00, s.busopt}
                                                                    : reg_rdata;
                            end else if (rx[7:1] == `SSS_ARA_ADDR && rx[0]
                                         && !s.busopt[`SSS_BUSOPT_ARA_DIS]
                                         && ev_int_mode && !ev_pol_high && ev_asserted) begin
                                n.tgt = TG_ARA;
                                n.ack = 1'b1;
                            end else if (rx[7:4] == `SSS_FIX_PROT && !s.permanent_protect_cmd) begin
                                n.tgt = TG_PROT;
                                if (s.ps.ov && s.ps.sel[2:1] == 2'b00 && rx[3:2] == 2'b00) begin
                                    n.pcmd = PC_REV;
                                    n.ack = !s.reversible_protect_cmd;
                                end else if (s.ps.ov && s.ps.sel[2:1] == 2'b01
                                             && rx[3:2] == 2'b01) begin
                                    n.pcmd = PC_CLEAR;
                                    n.ack = 1'b1;
                                end else if (!s.ps.ov && rx[3:1] == s.ps.sel) begin
                                    n.pcmd = PC_PERM;
                                    n.ack = 1'b1;
                                end
                            end
                        end else if (s.tgt == TG_MEM) begin
                            if (s.byte_n == 3'h1) begin
                                n.mem_addr = rx;
                            end else if (!s.mem_addr[`SSS_LOWER_BIT] && (s.reversible_protect_cmd || s.permanent_protect_cmd)) begin
                                n.ack = 1'b0;
                            end else begin
                                n.pbuf[s.mem_addr[3:0]] = rx;
                                n.pmask[s.mem_addr[3:0]] = 1'b1;
                                // only the low nibble counts, so the page wraps
                                n.mem_addr = {s.mem_addr[7:4], s.mem_addr[3:0] + 4'h1};
                                n.wr_pend = 1'b1;
                            end
                        end else if (s.tgt == TG_TS) begin
                            if (s.byte_n == 3'h1) begin
                                n.ptr = rx;
                            end else if (s.byte_n == 3'h2) begin
                                n.hi = rx;
                            end else if (s.byte_n == 3'h3) begin
                                n.reg_we = 1'b1;
                                n.reg_wdata = {s.hi, rx};
                                if (s.ptr == `SSS_PTR_BUSOPT) begin
                                    n.busopt = rx;
                                end
                            end
                        end else if (s.tgt == TG_PROT && s.byte_n == 3'h2) begin
                            // clearing unprotected part acks, starts no cycle
                            n.prot_pend = (s.pcmd != PC_CLEAR) || s.reversible_protect_cmd;
                        end
                    end
                end
            end
            ST_ACKW: begin
                if (fall) begin
                    n.sda_oe = s.ack;
                    n.st = ST_ACK;
                end
            end
            ST_ACK: begin
                if (fall) begin
                    n.sda_oe = 1'b0;
                    if (!s.ack) begin
                        n.st = ST_IDLE;
                    end else if (s.rw) begin
                        load = 1'b1;
                    end else begin
                        n.st = ST_RX;
                        n.bitc = 4'h0;
                    end
                end
            end
            ST_TX: begin
                if (rise && s.tgt == TG_ARA && !s.sda_oe && !s.ps.sda) begin
                    n.st = ST_IDLE;
                end else if (fall) begin
                    if (s.bitc == 4'h8) begin
                        n.sda_oe = 1'b0;
                        n.st = ST_HACK;
                    end else begin
                        n.sda_oe = ~s.sh[7];
                        n.sh = {s.sh[6:0], 1'b0};
                        n.bitc = s.bitc + 1'b1;
                    end
                end
            end
            ST_HACK: begin
                if (rise) begin
                    n.ack = ~s.ps.sda;
                    if (s.tgt == TG_ARA) begin
                        n.ev_clr = 1'b1;
                    end
                end else if (fall) begin
                    if (s.ack && s.tgt != TG_ARA) begin
                        load = 1'b1;
                    end else begin
                        n.st = ST_IDLE;
                    end
                end
            end
            default: begin
            end
        endcase

        // next read byte; memory address runs over the whole array
        if (load) begin
            n.sh = {tx_next[6:0], 1'b0};
            n.sda_oe = ~tx_next[7];
            n.bitc = 4'h1;
            n.st = ST_TX;
            n.rd_lo = ~s.rd_lo;
            if (s.tgt == TG_MEM) begin
                n.mem_addr = s.mem_addr + 8'h01;
            end
        end

        // start: pending data is kept while a write cycle still needs it
        if (s.scl_d && s.ps.scl && s.sda_d && !s.ps.sda) begin
            n.st = ST_RX;
            n.bitc = 4'h0;
            n.byte_n = 3'h0;
            n.sda_oe = 1'b0;
            if (!s.busy) begin
                n.wr_pend = 1'b0;
                n.prot_pend = 1'b0;
                n.pmask = '0;
            end
        end

        // stop launches the internal write
        if (s.scl_d && s.ps.scl && !s.sda_d && s.ps.sda) begin
            n.st = ST_IDLE;
            n.sda_oe = 1'b0;
            if ((s.wr_pend || s.prot_pend) && !s.busy) begin
                n.busy = 1'b1;
                n.busy_cnt = '0;
            end
        end

        // bus hang guard
        if (!s.busopt[`SSS_BUSOPT_TO_DIS] && s.to_cnt == TO_LIM) begin
            n.st = ST_IDLE;
            n.sda_oe = 1'b0;
        end
    end

    // state register; protection reloads from nonvolatile cells
    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '0;
            s.pm.scl <= 1'b1;
            s.pm.sda <= 1'b1;
            s.ps.scl <= 1'b1;
            s.ps.sda <= 1'b1;
            s.scl_d <= 1'b1;
            s.sda_d <= 1'b1;
            s.st <= ST_IDLE;
            s.ptr <= `SSS_PTR_RESET;
            s.busopt <= `SSS_BUSOPT_RESET;
            s.reversible_protect_cmd <= nv_rwp;
            s.permanent_protect_cmd <= nv_pwp;
        end else begin
            s <= n;
        end
    end

    // eeprom array, no reset; commit writes every loaded page byte
    always_ff @(posedge mclk) begin
        if (s.commit) begin
            for (int i = 0; i < `SSS_PAGE_BYTES; i++) begin
                if (s.pmask[i]) begin
                    mem[{s.mem_addr[7:4], 4'(i)}] <= s.pbuf[i];
                end
            end
        end
    end

    // open drain: line only ever pulled low
    assign sda_pin_out = 1'b0;
    assign sda_pin_oe = s.sda_oe;
    assign reg_ptr = s.ptr;
    assign reg_wdata = s.reg_wdata;
    assign reg_we = s.reg_we;
    assign temp_latch = s.conv_tick;
    assign event_clear = s.ev_clr;
    assign prot_rwp = s.reversible_protect_cmd;
    assign prot_pwp = s.permanent_protect_cmd;
    assign write_busy = s.busy;

endmodule

/* File: hdl/sss_consts.svh */
// sss_consts.svh: offsets, field positions, reset values and timing for the serial slave
// assumes: included by sss_pkg by bare name; the slave module sees its macros through it
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH

// clock rate and printed times
`define SSS_MCLK_KHZ 50000
`define SSS_TIMEOUT_MS 35
`define SSS_CONV_MS 125
`define SSS_WRITE_MS 5
`define SSS_CNT_W 23

// address fields (7-bit addresses)
`define SSS_FIX_MEM 4'hA
`define SSS_FIX_PROT 4'h6
`define SSS_FIX_TS 4'h3
`define SSS_ARA_ADDR 7'h0C

// pointer and bus option register
`define SSS_PTR_RESET 8'h00
`define SSS_PTR_BUSOPT 8'h22
`define SSS_BUSOPT_RESET 8'h21
`define SSS_BUSOPT_TO_DIS 7
`define SSS_BUSOPT_ARA_DIS 0

// eeprom geometry
`define SSS_PAGE_BYTES 16
`define SSS_MEM_BYTES 256
`define SSS_LOWER_BIT 7

`endif

/* File: hdl/sss_pkg.sv */
// sss_pkg: types shared by the serial slave
// assumes: sss_consts.svh on the include path
package sss_pkg;
`include "sss_consts.svh"

    // pins after synchronising, scl first
    typedef struct packed {
        logic scl;
        logic sda;
        logic ov;
        logic [2:0] sel;
    } sss_pins_s;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX = 6'h02,
        ST_ACKW = 6'h04,
        ST_ACK = 6'h08,
        ST_TX = 6'h10,
        ST_HACK = 6'h20
    } sss_state_e;

    typedef enum logic [1:0] {TG_MEM, TG_TS, TG_PROT, TG_ARA} sss_tgt_e;

    // permanent_protect_cmd, reversible_protect_cmd, clear_reversible_protect_cmd
    typedef enum logic [1:0] {PC_PERM, PC_REV, PC_CLEAR} sss_pcmd_e;

    typedef struct packed {
        sss_pins_s pm;
        sss_pins_s ps;
        logic scl_d;
        logic sda_d;
        sss_state_e st;
        logic [7:0] sh;
        logic [3:0] bitc;
        logic [2:0] byte_n;
        sss_tgt_e tgt;
        sss_pcmd_e pcmd;
        logic rw;
        logic ack;
        logic rd_lo;
        logic [7:0] mem_addr;
        logic [7:0] ptr;
        logic [7:0] busopt;
        logic [15:0] rdw;
        logic [7:0] hi;
        logic [15:0][7:0] pbuf;
        logic [15:0] pmask;
        logic wr_pend;
        logic prot_pend;
        logic busy;
        logic [`SSS_CNT_W-1:0] busy_cnt;
        logic [`SSS_CNT_W-1:0] to_cnt;
        logic [`SSS_CNT_W-1:0] conv_cnt;
        logic conv_tick;
        logic commit;
        logic reversible_protect_cmd;
        logic permanent_protect_cmd;
        logic reg_we;
        logic [15:0] reg_wdata;
        logic ev_clr;
        logic sda_oe;
    } sss_core_s;
endpackage

/* File: verif/sss_serial_slave_asserts.sv */
// sss_chk: port checks on the serial slave
// assumes: bound into sss_serial_slave with its parameters
`timescale 1ns/100ps
module sss_chk
    import sss_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = 200,
    parameter int unsigned CONV_CYC = 200,
    parameter int unsigned WRITE_CYC = 200
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_pin,
    input wire logic sda_pin_oe,
    input wire logic ev_int_mode,
    input wire logic ev_pol_high,
    input wire logic [7:0] reg_ptr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_we,
    input wire logic temp_latch,
    input wire logic event_clear,
    input wire logic prot_rwp,
    input wire logic prot_pwp,
    input wire logic write_busy
);
    logic to_dis;
    logic ara_dis;
    logic seen;
    logic [31:0] lo_cnt;
    logic [31:0] cv_cnt;
    logic [31:0] bz_cnt;

    // bus option shadow from forwarded writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            to_dis <= 1'b0;
            ara_dis <= 1'b1;
            seen <= 1'b0;
            lo_cnt <= '0;
            cv_cnt <= '0;
            bz_cnt <= '0;
        end else begin
            if (reg_we && reg_ptr == 8'h22) begin
                to_dis <= reg_wdata[7];
                ara_dis <= reg_wdata[0];
            end
            lo_cnt <= scl_pin ? '0 : lo_cnt + 1;
            cv_cnt <= temp_latch ? 32'h1 : cv_cnt + 1;
            seen <= seen | temp_latch;
            bz_cnt <= write_busy ? bz_cnt + 1 : '0;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_we_once;
        reg_we ##1 !reg_we;
    endsequence
    sequence s_ara_ok;
        ev_int_mode && !ev_pol_high && !ara_dis;
    endsequence

    property p_ptr_rst;
        @(posedge mclk) disable iff (1'b0) rst |=> reg_ptr == 8'h00;
    endproperty
    // margin of 8 covers the pin synchroniser
    property p_to;
        lo_cnt > TIMEOUT_CYC + 8 && !to_dis |-> !sda_pin_oe;
    endproperty
    property p_conv;
        seen |-> temp_latch == (cv_cnt == CONV_CYC);
    endproperty
    property p_we;
        reg_we |-> s_we_once;
    endproperty
    property p_evc;
        event_clear |-> s_ara_ok;
    endproperty
    property p_oe_edge;
        $changed(sda_pin_oe) |-> !scl_pin;
    endproperty
    property p_busy_quiet;
        write_busy |-> !sda_pin_oe;
    endproperty
    property p_wcyc;
        $fell(write_busy) |-> bz_cnt >= WRITE_CYC - 2 && bz_cnt <= WRITE_CYC + 2;
    endproperty
    property p_pwp_keep;
        prot_pwp |=> prot_pwp && $stable(prot_rwp);
    endproperty
    property p_prot_cyc;
        $changed(prot_rwp) || $rose(prot_pwp) |-> $past(write_busy) || $past(write_busy, 2);
    endproperty

    a_ptr_rst: assert property (p_ptr_rst)
        else $error("pointer not reset");
    a_to: assert property (p_to)
        else $error("sda held past timeout");
    a_conv: assert property (p_conv)
        else $error("latch period wrong");
    a_we: assert property (p_we)
        else $error("write strobe too long");
    a_evc: assert property (p_evc)
        else $error("bad event clear");
    a_oe_edge: assert property (p_oe_edge)
        else $error("sda changed with scl high");
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("sda driven while busy");
    a_wcyc: assert property (p_wcyc)
        else $error("write length wrong");
    a_pwp_keep: assert property (p_pwp_keep)
        else $error("protection changed after lock");
    a_prot_cyc: assert property (p_prot_cyc)
        else $error("protection change without cycle");
endmodule

bind sss_serial_slave sss_chk #(
    .TIMEOUT_CYC(TIMEOUT_CYC),
    .CONV_CYC(CONV_CYC),
    .WRITE_CYC(WRITE_CYC)
) u_chk (
    .mclk(mclk),
    .rst(rst),
    .scl_pin(scl_pin),
    .sda_pin_oe(sda_pin_oe),
    .ev_int_mode(ev_int_mode),
    .ev_pol_high(ev_pol_high),
    .reg_ptr(reg_ptr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .temp_latch(temp_latch),
    .event_clear(event_clear),
    .prot_rwp(prot_rwp),
    .prot_pwp(prot_pwp),
    .write_busy(write_busy)
);

/* File: verif/sss_host_model.sv */
// sss_host_model: bus host; drives scl, pulls sda low
// assumes: bench wires sda from every pull-down enable
`timescale 1ns/100ps
module sss_host_model (
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    logic r;

    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // one 160 ns bit; long low phase covers the slave's synchroniser
    task automatic bitx(input logic b, output logic q);
        #50 sda_oe = !b;
        #50 scl = 1'b1;
        #30 q = sda;
        #30 scl = 1'b0;
    endtask
    // also serves as repeated start before a read
    task automatic start();
        #50 sda_oe = 1'b0;
        #50 scl = 1'b1;
        #50 sda_oe = 1'b1;
        #50 scl = 1'b0;
    endtask
    // stop ends every write and starts the internal write
    task automatic stop();
        #50 sda_oe = 1'b1;
        #50 scl = 1'b1;
        #50 sda_oe = 1'b0;
        #50;
    endtask
    // msb first, leaves clock low before the acknowledge bit
    task automatic bits8(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
    endtask
    // address, pointer and data bytes each take an acknowledge
    task automatic tx(input logic [7:0] d, output logic ack);
        bits8(d);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rx(input logic nack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(nack, r);
    endtask
endmodule

/* File: verif/testbench.sv */
// testbench: drives the slave via the host model, judges answers
// assumes: long counts cut to 200 cycles; one slave on open drain
`timescale 1ns/100ps
module testbench;
    import sss_pkg::*;
    localparam int unsigned CYC = 200;
    logic mclk, rst, ov, int_m, pol, ev_on, nv_r, nv_p, ak, we, tl, ec, prwp, ppwp, busy;
    logic d_oe, h_oe, scl;
    logic ec_seen = 1'b0;
    logic [2:0] sel;
    logic [15:0] rdata, wd;
    logic [7:0] ptr, b;
    int n_errors, n_tests;
    int cyc = 0;
    // wired-and bus with pull-up
    wire sda = !(d_oe || h_oe);

    sss_serial_slave #(.TIMEOUT_CYC(CYC), .CONV_CYC(CYC), .WRITE_CYC(CYC)) DUT (
        .mclk(mclk), .rst(rst), .scl_pin(scl), .sda_pin_in(sda), .sda_pin_out(),
        .sda_pin_oe(d_oe), .select_pin_low(sel[0]), .select_pin_mid(sel[1]),
        .select_pin_high(sel[2]), .overvoltage_detect(ov), .ev_int_mode(int_m),
        .ev_pol_high(pol), .ev_asserted(ev_on), .reg_rdata(rdata), .nv_rwp(nv_r),
        .nv_pwp(nv_p), .reg_ptr(ptr), .reg_wdata(wd), .reg_we(we), .temp_latch(tl),
        .event_clear(ec), .prot_rwp(prwp), .prot_pwp(ppwp), .write_busy(busy));
    sss_host_model host (.scl(scl), .sda_oe(h_oe), .sda(sda));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // hang guard, run takes about 7500 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (ec === 1'b1) begin
            ec_seen <= 1'b1;
        end
        if (cyc == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chkv(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkb(input logic g, input logic e);
        chkv({15'h0, g}, {15'h0, e});
    endtask
    task automatic txc(input logic [7:0] d, input logic e);
        host.tx(d, ak);
        chkb(ak, e);
    endtask
    task automatic rxc(input logic nack, input logic [7:0] e);
        host.rx(nack, b);
        chkv({8'h00, b}, {8'h00, e});
    endtask
    // bounded wait for write end
    task automatic wait_idle();
        repeat (4) @(posedge mclk);
        for (int k = 0; k < 400 && busy; k++) begin
            @(posedge mclk);
        end
        chkb(busy, 1'b0);
    endtask
    // protection command; overvoltage only while it runs
    task automatic pcmd(input logic [2:0] s, input logic o, input logic [7:0] a, input logic e);
        @(posedge mclk);
        sel <= s;
        ov <= o;
        host.start();
        txc(a, e);
        if (!a[0]) begin
            txc(8'h00, e);
            txc(8'h00, e);
        end
        host.stop();
        wait_idle();
        ov <= 1'b0;
        sel <= 3'h0;
    endtask
    task automatic araq(input logic e);
        host.start();
        txc(8'h19, e);
        if (e) begin
            rxc(1'b1, 8'h30);
        end
        host.stop();
    endtask
    task automatic rd_at(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
        host.start();
        txc(8'hA0, 1'b1);
        txc(a, 1'b1);
        host.start();
        txc(8'hA1, 1'b1);
        rxc(1'b0, e0);
        rxc(1'b1, e1);
        host.stop();
    endtask

    task automatic t_reset();
        chkv({8'h00, ptr}, 16'h0000);
        chkb(prwp, 1'b1);
        chkb(ppwp, 1'b0);
    endtask
    task automatic t_timeout();
        host.start();
        host.bits8(8'hA0);
        repeat (6) @(posedge mclk);
        chkb(d_oe, 1'b1);
        repeat (CYC + 20) @(posedge mclk);
        chkb(d_oe, 1'b0);
        host.stop();
    endtask
    task automatic t_sensor();
        host.start();
        txc(8'h30, 1'b1);
        txc(8'h05, 1'b1);
        txc(8'hAB, 1'b1);
        txc(8'hCD, 1'b1);
        host.stop();
        chkv(wd, 16'hABCD);
        chkv({8'h00, ptr}, 16'h0005);
        host.start();
        txc(8'h31, 1'b1);
        rxc(1'b0, 8'h5A);
        rxc(1'b1, 8'h3C);
        host.stop();
        chkv({8'h00, ptr}, 16'h0005);
    endtask
    task automatic t_alert();
        araq(1'b0);
        host.start();
        txc(8'h30, 1'b1);
        txc(8'h22, 1'b1);
        txc(8'h00, 1'b1);
        txc(8'h20, 1'b1);
        host.stop();
        ev_on <= 1'b1;
        araq(1'b0);
        int_m <= 1'b1;
        pol <= 1'b1;
        araq(1'b0);
        pol <= 1'b0;
        araq(1'b1);
        chkb(ec_seen, 1'b1);
    endtask
    task automatic t_rwp();
        host.start();
        txc(8'hA0, 1'b1);
        txc(8'h05, 1'b1);
        txc(8'h77, 1'b0);
        host.stop();
        repeat (6) @(posedge mclk);
        chkb(busy, 1'b0);
        pcmd(3'h0, 1'b1, 8'h60, 1'b0);
        pcmd(3'h0, 1'b1, 8'h61, 1'b0);
        pcmd(3'h2, 1'b1, 8'h65, 1'b1);
        pcmd(3'h2, 1'b1, 8'h64, 1'b1);
        chkb(prwp, 1'b0);
        pcmd(3'h0, 1'b1, 8'h60, 1'b1);
        chkb(prwp, 1'b1);
        pcmd(3'h2, 1'b1, 8'h64, 1'b1);
        chkb(prwp, 1'b0);
    endtask
    task automatic t_eeprom();
        host.start();
        txc(8'hA0, 1'b1);
        txc(8'h00, 1'b1);
        txc(8'h5A, 1'b1);
        host.stop();
        repeat (4) @(posedge mclk);
        chkb(busy, 1'b1);
        araq(1'b0);
        host.start();
        txc(8'hA1, 1'b0);
        host.stop();
        wait_idle();
        host.start();
        txc(8'hA2, 1'b0);
        host.stop();
        host.start();
        txc(8'hA0, 1'b1);
        txc(8'hF0, 1'b1);
        for (int i = 0; i < 17; i++) begin
            txc(8'h10 + 8'(i), 1'b1);
        end
        host.stop();
        wait_idle();
        rd_at(8'hFF, 8'h1F, 8'h5A);
        rd_at(8'hF0, 8'h20, 8'h11);
    endtask
    task automatic t_pwp();
        pcmd(3'h0, 1'b0, 8'h60, 1'b1);
        chkb(ppwp, 1'b1);
        pcmd(3'h0, 1'b0, 8'h61, 1'b0);
        pcmd(3'h2, 1'b1, 8'h64, 1'b0);
    endtask

    initial begin
        {rst, ov, int_m, pol, ev_on, nv_r, nv_p} = 7'h42;
        sel = 3'h0;
        rdata = 16'h5A3C;
        n_errors = 0;
        n_tests = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_reset();
        t_timeout();
        t_sensor();
        t_alert();
        t_rwp();
        t_eeprom();
        t_pwp();
        tally_and_finish();
    end
endmodule
